// file: test/led_behavior_pulse_sequencer_test.sv
// testbench: wishbone register access and led behaviors seen at the pin
`timescale 1ns/1ps
module led_behavior_pulse_sequencer_test;
  // ****************
  // signals
  // ****************
  localparam int P   = 1600; // period code 8 at 200 cycles per unit, short for sim
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic        touch = 1'b0;
  logic        pol   = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [31:0] wdat  = 32'h00000000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        led;
  logic        oe;
  logic        pin;
  logic        lit;
  logic [7:0]  rd;
  int          failures  = 0;
  int          tests_run = 0;
  int          n;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  led_behavior_pulse_sequencer #(.UNIT_CYC(200), .RAMP_CYC(50)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .touch_i(touch), .led_o(led), .led_oe_o(oe)
  );

  led_pin_model pin_u (
    .drive_i(led), .oe_i(oe), .active_high_i(pol), .pin_o(pin), .lit_o(lit)
  );

  // ****************
  // tasks
  // ****************
  // one classic cycle; the request stands until ack is sampled high
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {2'b00, idx, 2'b00};
    wdat <= {24'h000000, wd};
    sel  <= 4'hF;
    // no cycle count assumed: a slave that never answers is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    xfer(1'b1, idx, wd);
  endtask : wr

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask : rchk

  // counts cycles with the led lit; the pin lags the pwm, so windows are generous
  task lit_count(input int cycles);
    n = 0;
    repeat (cycles) begin
      @(posedge clk_i);
      if (lit === 1'b1) n++;
    end
  endtask : lit_count

  task test_done;
    if (failures == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // ****************
  // tests
  // ****************
  // ctrl 0x0A = push-pull, active high; low bit is the drive bit
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("idle pin", pin, 1'b1);
    check("idle oe", oe, 1'b0);
    rchk("p1 period", led_seq_pkg::IDX_PULSE_ONE_PERIOD_CODE, 8'h20);
    rchk("p2 period", led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE, 8'h14);
    rchk("counts", led_seq_pkg::IDX_CONFIG, 8'h04);
    rchk("unmapped", 8'h3F, 8'h00);
    wr(led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE, 8'hFF);
    rchk("p2 width", led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE, 8'h7F);
    pol <= 1'b1;
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    repeat (300) @(posedge clk_i);
    lit_count(200);
    check("direct on", n, 200);
    rchk("direct level", led_seq_pkg::IDX_STATUS, 8'hE4);
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    repeat (300) @(posedge clk_i);
    lit_count(200);
    check("direct off", n, 0);
    wr(led_seq_pkg::IDX_CTRL, 8'h0E);
    touch <= 1'b1;
    repeat (300) @(posedge clk_i);
    lit_count(200);
    check("touch on", n, 200);
    touch <= 1'b0;
    repeat (300) @(posedge clk_i);
    lit_count(200);
    check("release off", n, 0);
    // slow rise: the level must climb, not jump, then reach the maximum
    wr(led_seq_pkg::IDX_RATES, 8'h3F);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    xfer(1'b0, led_seq_pkg::IDX_STATUS, 8'h00);
    check("ramp start", rd[6:0] < 7'h64, 1'b1);
    repeat (600) @(posedge clk_i);
    xfer(1'b0, led_seq_pkg::IDX_STATUS, 8'h00);
    check("ramp top", rd[6:0], 7'h64);
    // open drain: on level is released to the pull-up, off level is driven
    wr(led_seq_pkg::IDX_RATES, 8'h00);
    wr(led_seq_pkg::IDX_CTRL, 8'h03);
    repeat (300) @(posedge clk_i);
    check("od on oe", oe, 1'b0);
    check("od on lit", lit, 1'b1);
    wr(led_seq_pkg::IDX_CTRL, 8'h02);
    repeat (300) @(posedge clk_i);
    check("od off oe", oe, 1'b1);
    check("od off lit", lit, 1'b0);
    // pulse 1, three breaths, then settle at minimum
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    wr(led_seq_pkg::IDX_CONFIG, 8'h02);
    wr(led_seq_pkg::IDX_PULSE_ONE_PERIOD_CODE, 8'h08);
    wr(led_seq_pkg::IDX_BEHAVIOR, 8'h01);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    lit_count(P);
    check("p1 first", n > 0, 1'b1);
    // clearing the bit mid-run is no stop trigger for pulse 1
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    lit_count(P);
    check("p1 second", n > 0, 1'b1);
    repeat (2 * P) @(posedge clk_i);
    lit_count(P);
    check("p1 ended", n, 0);
    // start on release: setting the bit must not start, clearing must
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    wr(led_seq_pkg::IDX_PULSE_ONE_PERIOD_CODE, 8'h88);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    lit_count(P);
    check("p1 set ignored", n, 0);
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    lit_count(P);
    check("p1 on clear", n > 0, 1'b1);
    repeat (3 * P) @(posedge clk_i);
    // pulse 2 runs until cleared, then one more pulse
    wr(led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE, 8'h08);
    wr(led_seq_pkg::IDX_BEHAVIOR, 8'h02);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    repeat (3 * P) @(posedge clk_i);
    lit_count(P);
    check("p2 running", n > 0, 1'b1);
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    repeat (3 * P) @(posedge clk_i);
    lit_count(P);
    check("p2 settled", n, 0);
    // breathe swings between 0 and 100 percent, stops on clear
    wr(led_seq_pkg::IDX_BR_PER, 8'h08);
    wr(led_seq_pkg::IDX_BEHAVIOR, 8'h03);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    lit_count(P);
    check("breathe lit", n > 0 && n < P, 1'b1);
    wr(led_seq_pkg::IDX_CTRL, 8'h0A);
    repeat (P) @(posedge clk_i);
    lit_count(P);
    check("breathe stop", n, 0);
    // a period too short to meet still breathes
    wr(led_seq_pkg::IDX_BR_PER, 8'h01);
    wr(led_seq_pkg::IDX_CTRL, 8'h0B);
    lit_count(P);
    check("short period", n > 0, 1'b1);
    test_done;
  end

  // watchdog, well beyond the roughly 38500 cycles the tests need
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    test_done;
  end
endmodule : led_behavior_pulse_sequencer_test

// file: test/led_pin_model.sv
// led pin model: pull-up on the pin, led lit when the pin sits at its active level
`timescale 1ns/1ps
module led_pin_model (
  input  wire logic drive_i,
  input  wire logic oe_i,
  input  wire logic active_high_i,
  output logic      pin_o,
  output logic      lit_o
);
  // a released open-drain pin floats up through the pull-up, never holds the last value
  assign pin_o = oe_i ? drive_i : 1'b1;
  // the led conducts only at the level that the polarity setting calls active
  assign lit_o = (pin_o === active_high_i);
endmodule : led_pin_model

// file: verilog/led_behavior_pulse_sequencer.sv
// led behavior sequencer: wishbone registers, pulse/breathe sequencing and pwm pin drive
`timescale 1ns/1ps
module led_behavior_pulse_sequencer #(
  parameter int unsigned UNIT_CYC = led_seq_pkg::UNIT_CYC,
  parameter int unsigned RAMP_CYC = led_seq_pkg::RAMP_CYC
) (
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [led_seq_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]                    wb_dat_i,
  input  wire logic [3:0]                     wb_sel_i,
  output logic      [31:0]                    wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic                           touch_i,
  output logic                                led_o,
  output logic                                led_oe_o
);

  // ********************************************
  // state
  // ********************************************
  typedef struct packed {
    logic [1:0]      behavior;
    logic [7:0]      pulse_one_period_code;
    logic [6:0]      pulse_two_period_code;
    logic [6:0]      br_per;
    logic [5:0]      cfg;
    logic [3:0][7:0] duty;
    logic [5:0]      rates;
    logic [3:0]      ctrl;
    led_seq_pkg::seq_t state;
    logic            act_q;
    logic [3:0]      pulses_left;
    logic [6:0]      unit_cnt;
    logic [31:0]     tick_cnt;
    logic [31:0]     acc;
    logic [6:0]      level;
    logic [7:0]      div_cnt;
    logic [6:0]      slot;
    logic [6:0]      duty_q;
    logic            led;
    logic            ack;
    logic [7:0]      rdata;
  } state_t;

  state_t s;
  state_t next_s;
  led_seq_pkg::behavior_t beh;
  logic        act, rise_ev, fall_ev, start_ev, tick, pulse_end, up, wr, hit;
  logic        pwm_en, frame_end, pwm_on;
  logic [2:0]  rate, cnt1, cnt2, rise_r, fall_r;
  logic [6:0]  dmax, dmin, span, per_code, eff, target;
  logic [7:0]  idx, rd_mux, duty_sel, pwm_div;
  logic [31:0] period_cyc, ramp_cyc;

  // ********************************************
  // next state
  // ********************************************
  always_comb begin
    next_s = s;
    beh    = led_seq_pkg::behavior_t'(s.behavior);
    cnt1   = s.cfg[led_seq_pkg::CNT_ONE_LSB +: 3];
    cnt2   = s.cfg[led_seq_pkg::CNT_TWO_LSB +: 3];
    rise_r = s.rates[led_seq_pkg::RISE_LSB +: 3];
    fall_r = s.rates[led_seq_pkg::FALL_LSB +: 3];

    // bus slave: ack one cycle after the request, unmapped reads give zero
    idx = wb_adr_i[9:2];
    hit = (wb_adr_i[led_seq_pkg::ADR_W-1:10] == 2'h0);
    next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
    wr = next_s.ack & wb_we_i & wb_sel_i[0] & hit;
    rd_mux = 8'h00;
    if (hit) begin
      unique case (idx)
        led_seq_pkg::IDX_CTRL:     rd_mux = {4'h0, s.ctrl};
        led_seq_pkg::IDX_STATUS:   rd_mux = {s.led, s.level};
        led_seq_pkg::IDX_BEHAVIOR: rd_mux = {6'h00, s.behavior};
        led_seq_pkg::IDX_PULSE_ONE_PERIOD_CODE:   rd_mux = s.pulse_one_period_code;
        led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE:   rd_mux = {1'b0, s.pulse_two_period_code};
        led_seq_pkg::IDX_BR_PER:   rd_mux = {1'b0, s.br_per};
        led_seq_pkg::IDX_CONFIG:   rd_mux = {2'h0, s.cfg};
        led_seq_pkg::IDX_RATES:    rd_mux = {2'h0, s.rates};
        default: begin
          if (idx[7:2] == led_seq_pkg::IDX_DUTY0[7:2]) begin
            rd_mux = s.duty[idx[1:0]];
          end
        end
      endcase
    end
    next_s.rdata = rd_mux;
    if (wr) begin
      unique case (idx)
        led_seq_pkg::IDX_CTRL:     next_s.ctrl = wb_dat_i[3:0];
        led_seq_pkg::IDX_BEHAVIOR: next_s.behavior = wb_dat_i[1:0];
        led_seq_pkg::IDX_PULSE_ONE_PERIOD_CODE:   next_s.pulse_one_period_code = wb_dat_i[7:0];
        led_seq_pkg::IDX_PULSE_TWO_PERIOD_CODE:   next_s.pulse_two_period_code = wb_dat_i[6:0];
        led_seq_pkg::IDX_BR_PER:   next_s.br_per = wb_dat_i[6:0];
        led_seq_pkg::IDX_CONFIG:   next_s.cfg = wb_dat_i[5:0];
        led_seq_pkg::IDX_RATES:    next_s.rates = wb_dat_i[5:0];
        default: begin
          if (idx[7:2] == led_seq_pkg::IDX_DUTY0[7:2]) begin
            next_s.duty[idx[1:0]] = wb_dat_i[7:0];
          end
        end
      endcase
    end

    // actuation source: touch when linked, else the drive bit
    act = s.ctrl[led_seq_pkg::CTRL_LINK_BIT] ? touch_i
                                             : s.ctrl[led_seq_pkg::CTRL_DRIVE_BIT];
    rise_ev = act & ~s.act_q;
    fall_ev = ~act & s.act_q;
    next_s.act_q = act;
    start_ev = (beh == led_seq_pkg::BEH_PULSE_ONE &&
                s.pulse_one_period_code[led_seq_pkg::START_ON_RELEASE_BIT]) ? fall_ev : rise_ev;

    // duty set per behavior: pulse1, pulse2, breathe, direct
    duty_sel = s.duty[2'(s.behavior - 2'h1)];
    dmax = led_seq_pkg::DUTY_MAX_PCT[duty_sel[led_seq_pkg::DUTY_MAX_LSB +: 4]];
    dmin = led_seq_pkg::DUTY_MIN_PCT[duty_sel[led_seq_pkg::DUTY_MIN_LSB +: 4]];
    span = (dmax > dmin) ? 7'(dmax - dmin) : 7'h00;

    // period in 32 ms units; code zero runs as one unit
    unique case (beh)
      led_seq_pkg::BEH_PULSE_ONE: per_code = s.pulse_one_period_code[6:0];
      led_seq_pkg::BEH_PULSE_TWO: per_code = s.pulse_two_period_code;
      default:                    per_code = s.br_per;
    endcase
    eff = (per_code == 7'h00) ? 7'h01 : per_code;
    period_cyc = 32'(eff) * 32'(UNIT_CYC);

    // timebase: one tick per period unit, held cleared while idle
    tick = (s.state != led_seq_pkg::SEQ_IDLE) && (s.tick_cnt == 32'(UNIT_CYC - 1));
    pulse_end = tick && (s.unit_cnt == 7'(eff - 7'h01));
    if (s.state == led_seq_pkg::SEQ_IDLE) begin
      next_s.tick_cnt = 32'h0;
      next_s.unit_cnt = 7'h00;
    end else if (tick) begin
      next_s.tick_cnt = 32'h0;
      next_s.unit_cnt = pulse_end ? 7'h00 : 7'(s.unit_cnt + 7'h01);
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h1;
    end

    // brightness: direct ramps by rise/fall time, patterns by bresenham over the period
    up = 1'b0;
    target = act ? dmax : dmin;
    rate = act ? rise_r : fall_r;
    ramp_cyc = 32'(rate) * 32'(RAMP_CYC);
    if (s.state == led_seq_pkg::SEQ_IDLE && beh == led_seq_pkg::BEH_DIRECT) begin
      if (rate == 3'h0) begin
        next_s.level = target;
        next_s.acc = 32'h0;
      end else if (s.acc + 32'(span) >= ramp_cyc) begin
        next_s.acc = 32'h0;
        if (s.level < target) begin
          next_s.level = 7'(s.level + 7'h01);
        end else if (s.level > target) begin
          next_s.level = 7'(s.level - 7'h01);
        end
      end else begin
        next_s.acc = s.acc + 32'(span);
      end
    end else if (s.state == led_seq_pkg::SEQ_IDLE) begin
      next_s.level = dmin;
      next_s.acc = 32'h0;
    end else begin
      // first half ramps up, second half down; an odd unit count splits its middle unit
      up = ({s.unit_cnt, 1'b0} < {1'b0, eff}) && !(({s.unit_cnt, 1'b0} + 8'h01 == {1'b0, eff}) &&
           ({s.tick_cnt, 1'b0} >= 33'(UNIT_CYC)));
      if (s.acc + 32'({span, 1'b0}) >= period_cyc) begin
        next_s.acc = s.acc + 32'({span, 1'b0}) - period_cyc;
        if (up && s.level < dmax) begin
          next_s.level = 7'(s.level + 7'h01);
        end else if (!up && s.level > dmin) begin
          next_s.level = 7'(s.level - 7'h01);
        end
      end else begin
        next_s.acc = s.acc + 32'({span, 1'b0});
      end
    end

    // sequencer; a start trigger in idle or tail restarts from the minimum, a running pulse 1 ignores it
    unique case (s.state)
      led_seq_pkg::SEQ_IDLE: begin
        if (start_ev && beh != led_seq_pkg::BEH_DIRECT) begin
          next_s.state = led_seq_pkg::SEQ_RUN;
          next_s.pulses_left = 4'(cnt1) + 4'h1;
          next_s.tick_cnt = 32'h0;
          next_s.acc = 32'h0;
          next_s.level = dmin;
        end
      end
      led_seq_pkg::SEQ_RUN: begin
        if (beh == led_seq_pkg::BEH_DIRECT) begin
          next_s.state = led_seq_pkg::SEQ_IDLE;
        end else if (beh == led_seq_pkg::BEH_PULSE_ONE) begin
          // no stop trigger: only the breath count ends it
          if (pulse_end && s.pulses_left <= 4'h1) begin
            next_s.state = led_seq_pkg::SEQ_IDLE;
            next_s.level = dmin;
          end else if (pulse_end) begin
            next_s.pulses_left = 4'(s.pulses_left - 4'h1);
            next_s.level = dmin;
          end
        end else if (fall_ev && beh == led_seq_pkg::BEH_BREATHE) begin
          next_s.state = led_seq_pkg::SEQ_IDLE;
        end else if (fall_ev) begin
          next_s.state = led_seq_pkg::SEQ_TAIL;
          next_s.pulses_left = 4'(cnt2) + 4'h1;
          next_s.tick_cnt = 32'h0;
          next_s.unit_cnt = 7'h00;
          next_s.acc = 32'h0;
          next_s.level = dmin;
        end else if (pulse_end) begin
          next_s.level = dmin;
        end
      end
      led_seq_pkg::SEQ_TAIL: begin
        if (rise_ev || beh != led_seq_pkg::BEH_PULSE_TWO) begin
          next_s.state = rise_ev ? led_seq_pkg::SEQ_RUN : led_seq_pkg::SEQ_IDLE;
          next_s.tick_cnt = 32'h0;
          next_s.unit_cnt = 7'h00;
          next_s.acc = 32'h0;
          next_s.level = dmin;
        end else if (pulse_end && s.pulses_left <= 4'h1) begin
          next_s.state = led_seq_pkg::SEQ_IDLE;
          next_s.level = dmin;
        end else if (pulse_end) begin
          next_s.pulses_left = 4'(s.pulses_left - 4'h1);
          next_s.level = dmin;
        end
      end
      default: next_s.state = led_seq_pkg::SEQ_IDLE;
    endcase

    // pwm slot rate: direct follows rise/fall, patterns follow the period
    if (beh == led_seq_pkg::BEH_DIRECT) begin
      pwm_div = 8'(rise_r) + 8'(fall_r) + 8'h01;
    end else begin
      pwm_div = 8'(eff >> 2) + 8'h01;
    end
    pwm_en = (s.div_cnt >= 8'(pwm_div - 8'h01));
    next_s.div_cnt = pwm_en ? 8'h00 : 8'(s.div_cnt + 8'h01);
    frame_end = pwm_en && (s.slot == 7'(led_seq_pkg::PWM_SLOTS - 7'h01));
    if (pwm_en) begin
      next_s.slot = frame_end ? 7'h00 : 7'(s.slot + 7'h01);
    end
    // duty only moves at frame edges, so fast ramps cannot outrun the pwm
    if (frame_end) begin
      next_s.duty_q = s.level;
    end
    pwm_on = (s.slot < s.duty_q);
    next_s.led = s.ctrl[led_seq_pkg::CTRL_POL_BIT] ? pwm_on : ~pwm_on;
  end

  // ********************************************
  // registers
  // ********************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.pulse_one_period_code   <= led_seq_pkg::RST_PULSE_ONE_PERIOD_CODE;
      s.pulse_two_period_code   <= led_seq_pkg::RST_PULSE_TWO_PERIOD_CODE;
      s.br_per   <= led_seq_pkg::RST_BR_PER;
      s.cfg      <= led_seq_pkg::RST_CONFIG;
      s.duty     <= {4{led_seq_pkg::RST_DUTY}};
      s.rates    <= led_seq_pkg::RST_RATES;
      s.ctrl     <= led_seq_pkg::RST_CTRL;
      s.state    <= led_seq_pkg::SEQ_IDLE;
      s.led      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // open drain drives only the low level; push-pull always drives
  assign led_o    = s.led;
  assign led_oe_o = s.ctrl[led_seq_pkg::CTRL_PUSH_PULL_BIT] | ~s.led;
  assign wb_dat_o = {24'h000000, s.rdata};
  assign wb_ack_o = s.ack;

  // ********************************************
  // assertions
  // ********************************************
  sequence s_p2_stop;
    s.state == led_seq_pkg::SEQ_RUN && beh == led_seq_pkg::BEH_PULSE_TWO && fall_ev;
  endsequence

  property p_ack_single;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");
  property p_breathe_start;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_IDLE && beh == led_seq_pkg::BEH_BREATHE &&
       !s.ctrl[led_seq_pkg::CTRL_LINK_BIT] && s.ctrl[led_seq_pkg::CTRL_DRIVE_BIT] && !s.act_q)
      |=> s.state == led_seq_pkg::SEQ_RUN && s.level == $past(dmin);
  endproperty
  a_breathe_start: assert property (p_breathe_start) else $error("drive bit did not start");
  property p_breathe_stop;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_RUN && beh == led_seq_pkg::BEH_BREATHE && fall_ev)
      |=> s.state == led_seq_pkg::SEQ_IDLE;
  endproperty
  a_breathe_stop: assert property (p_breathe_stop) else $error("breathe did not stop");
  property p_p1_count;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_IDLE && beh == led_seq_pkg::BEH_PULSE_ONE && start_ev)
      |=> s.state == led_seq_pkg::SEQ_RUN && s.pulses_left == 4'($past(cnt1)) + 4'h1;
  endproperty
  a_p1_count: assert property (p_p1_count) else $error("pulse count not loaded");
  property p_p1_release;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_IDLE && beh == led_seq_pkg::BEH_PULSE_ONE &&
       s.pulse_one_period_code[led_seq_pkg::START_ON_RELEASE_BIT] && rise_ev)
      |=> s.state == led_seq_pkg::SEQ_IDLE;
  endproperty
  a_p1_release: assert property (p_p1_release) else $error("pulse started on touch");
  property p_p1_no_stop;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_RUN && beh == led_seq_pkg::BEH_PULSE_ONE &&
       fall_ev && !pulse_end) |=> s.state == led_seq_pkg::SEQ_RUN;
  endproperty
  a_p1_no_stop: assert property (p_p1_no_stop) else $error("pulse one stopped");
  property p_p2_tail;
    @(posedge clk_i) disable iff (rst_i)
      s_p2_stop |=> s.state == led_seq_pkg::SEQ_TAIL && s.pulses_left == 4'($past(cnt2)) + 4'h1;
  endproperty
  a_p2_tail: assert property (p_p2_tail) else $error("pulse two tail wrong");
  property p_direct_jump;
    @(posedge clk_i) disable iff (rst_i)
      (s.state == led_seq_pkg::SEQ_IDLE && beh == led_seq_pkg::BEH_DIRECT && act &&
       rise_r == 3'h0) |=> s.level == $past(dmax);
  endproperty
  a_direct_jump: assert property (p_direct_jump) else $error("direct level wrong");
  property p_tick_gap;
    @(posedge clk_i) disable iff (rst_i) tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");
  property p_duty_frame;
    @(posedge clk_i) disable iff (rst_i) !frame_end |=> $stable(s.duty_q);
  endproperty
  a_duty_frame: assert property (p_duty_frame) else $error("duty moved mid frame");
  property p_idle_level;
    @(posedge clk_i) disable iff (rst_i)
      s.duty_q == 7'h00 |=> led_o == !$past(s.ctrl[led_seq_pkg::CTRL_POL_BIT]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("inactive level wrong");
endmodule : led_behavior_pulse_sequencer

// file: verilog/led_seq_pkg.sv
// package: register map, field layout, reset values and timing of the led sequencer
package led_seq_pkg;

  // ********************************************
  // register indices (byte address = 4 * index)
  // ********************************************
  localparam int unsigned ADR_W        = 12;
  localparam logic [7:0]  IDX_CTRL     = 8'h70;
  localparam logic [7:0]  IDX_STATUS   = 8'h71;
  localparam logic [7:0]  IDX_BEHAVIOR = 8'h81;
  localparam logic [7:0]  IDX_PULSE_ONE_PERIOD_CODE   = 8'h84;
  localparam logic [7:0]  IDX_PULSE_TWO_PERIOD_CODE   = 8'h85;
  localparam logic [7:0]  IDX_BR_PER   = 8'h86;
  localparam logic [7:0]  IDX_CONFIG   = 8'h88;
  localparam logic [7:0]  IDX_DUTY0    = 8'h90;
  localparam logic [7:0]  IDX_RATES    = 8'h94;

  // ********************************************
  // field positions
  // ********************************************
  localparam int unsigned START_ON_RELEASE_BIT = 7;
  localparam int unsigned CTRL_DRIVE_BIT       = 0;
  localparam int unsigned CTRL_POL_BIT         = 1;
  localparam int unsigned CTRL_LINK_BIT        = 2;
  localparam int unsigned CTRL_PUSH_PULL_BIT   = 3;
  localparam int unsigned CNT_ONE_LSB          = 0;
  localparam int unsigned CNT_TWO_LSB          = 3;
  localparam int unsigned DUTY_MIN_LSB         = 0;
  localparam int unsigned DUTY_MAX_LSB         = 4;
  localparam int unsigned FALL_LSB             = 0;
  localparam int unsigned RISE_LSB             = 3;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic [7:0] RST_PULSE_ONE_PERIOD_CODE   = 8'h20;
  localparam logic [6:0] RST_PULSE_TWO_PERIOD_CODE   = 7'h14;
  localparam logic [6:0] RST_BR_PER   = 7'h5D;
  localparam logic [5:0] RST_CONFIG   = 6'h04;
  localparam logic [7:0] RST_DUTY     = 8'hF0;
  localparam logic [5:0] RST_RATES    = 6'h00;
  localparam logic [3:0] RST_CTRL     = 4'h0;

  // ********************************************
  // timing
  // ********************************************
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned UNIT_MS   = 32;
  localparam int unsigned UNIT_CYC  = UNIT_MS * (CLK_HZ / 1000);
  localparam int unsigned RAMP_MS   = 250;
  localparam int unsigned RAMP_CYC  = RAMP_MS * (CLK_HZ / 1000);
  localparam logic [6:0]  PWM_SLOTS = 7'h64;

  // duty code to percent, entry 15 first
  localparam logic [15:0][6:0] DUTY_MAX_PCT = {7'h64, 7'h4D, 7'h3F, 7'h35, 7'h2E, 7'h28,
    7'h23, 7'h1E, 7'h1A, 7'h17, 7'h14, 7'h11, 7'h0E, 7'h0B, 7'h09, 7'h07};
  localparam logic [15:0][6:0] DUTY_MIN_PCT = {7'h4D, 7'h3F, 7'h35, 7'h2E, 7'h28, 7'h23,
    7'h1E, 7'h1A, 7'h17, 7'h14, 7'h11, 7'h0E, 7'h0B, 7'h09, 7'h07, 7'h00};

  typedef enum logic [1:0] {
    BEH_DIRECT    = 2'h0,
    BEH_PULSE_ONE = 2'h1,
    BEH_PULSE_TWO = 2'h2,
    BEH_BREATHE   = 2'h3
  } behavior_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RUN  = 2'h1,
    SEQ_TAIL = 2'h3
  } seq_t;

endpackage : led_seq_pkg
